// ==== hw/level_monitor_pkg.sv ====
package level_monitor_pkg;
	// ======================================================
	// register offsets
	localparam logic [11:0] ADDR_UPPER_LO   = 12'h247;
	localparam logic [11:0] ADDR_UPPER_HI   = 12'h248;
	localparam logic [11:0] ADDR_LOWER_LO   = 12'h249;
	localparam logic [11:0] ADDR_LOWER_HI   = 12'h24A;
	localparam logic [11:0] ADDR_DWELL_LO   = 12'h24B;
	localparam logic [11:0] ADDR_DWELL_HI   = 12'h24C;
	localparam logic [11:0] ADDR_MON_CTRL   = 12'h270;
	localparam logic [11:0] ADDR_PERIOD_0   = 12'h271;
	localparam logic [11:0] ADDR_PERIOD_1   = 12'h272;
	localparam logic [11:0] ADDR_PERIOD_2   = 12'h273;
	localparam logic [11:0] ADDR_PEAK_LO    = 12'h274;
	localparam logic [11:0] ADDR_PEAK_HI    = 12'h275;
	localparam logic [11:0] ADDR_SER_EN_A   = 12'h279;
	localparam logic [11:0] ADDR_SER_EN_B   = 12'h27A;
	localparam logic [11:0] ADDR_CB_SEL_A   = 12'h559;
	localparam logic [11:0] ADDR_CB_SEL_B   = 12'h55A;
	localparam logic [11:0] ADDR_OR_CLEAR   = 12'h562;
	localparam logic [11:0] ADDR_OR_STICKY  = 12'h563;
	localparam logic [11:0] ADDR_CB_SEL_C   = 12'h58F;
	// ======================================================
	// field positions and codes
	localparam int          PEAK_EN_BIT     = 1;
	localparam int          SER_EN_B_BIT    = 1;
	localparam logic [1:0]  SER_EN_A_MASK   = 2'h3;
	localparam logic [3:0]  CB_SRC_NONE     = 4'h0;
	localparam logic [3:0]  CB_SRC_OVER     = 4'h1;
	localparam logic [3:0]  CB_SRC_FAST     = 4'h2;
	localparam logic [3:0]  CB_SRC_SERIAL   = 4'h3;
	localparam logic [7:0]  SERIAL_SELECT   = 8'h01;
	localparam logic [7:0]  REG_RESET       = 8'h00;
	// ======================================================
	// sizes and timing
	localparam int          MAG_W           = 13;
	localparam int          PERIOD_W        = 24;
	localparam int          DWELL_W         = 16;
	localparam int          FAST_LATENCY    = 28;
	localparam int          FRAME_BITS      = 25;
	localparam int          SUBFRAME_BITS   = 5;
	localparam int          NUM_VCONV       = 8;
	localparam int          NUM_CHAN        = 2;
	localparam int          MAX_CB          = 3;
	localparam int          SAMPLE_LATENCY  = 4;
	localparam int          CLK_MHZ         = 100;
endpackage : level_monitor_pkg

// ==== hw/adc_level_monitor.sv ====
`timescale 1ns/10ps
module adc_level_monitor
	import level_monitor_pkg::*;
#(
	parameter int OR_LATENCY = SAMPLE_LATENCY
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic [NUM_CHAN*MAG_W-1:0] mag_i,
	input  wire logic [NUM_CHAN-1:0]   overrange_i,
	input  wire logic [NUM_VCONV-1:0]  vconv_over_i,
	input  wire logic                  dec_tick_i,
	input  wire logic [1:0]            control_bits_per_sample_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	input  wire logic [11:0]           reg_addr_i,
	input  wire logic [7:0]            reg_wdata_i,
	output logic      [7:0]            reg_rdata_o,
	output logic      [NUM_CHAN-1:0]   level_alarm_pin_o,
	output logic      [NUM_CHAN-1:0]   overrange_o,
	output logic      [MAX_CB-1:0]     ctrl_bits_o
);
	// ======================================================
	// registers
	logic [7:0]           upper_lo, upper_hi, lower_lo, lower_hi;
	logic [7:0]           dwell_lo, dwell_hi, mon_ctrl, ser_en_a, ser_en_b;
	logic [7:0]           cb_sel_a, cb_sel_b, cb_sel_c, or_clear, or_sticky;
	logic [PERIOD_W-1:0]  period_set;
	logic [MAG_W-1:0]     peak_hold;
	logic [MAG_W-1:0]     upper_thr, lower_thr;
	logic [DWELL_W-1:0]   dwell_thr;

	assign upper_thr = {upper_hi[4:0], upper_lo};
	assign lower_thr = {lower_hi[4:0], lower_lo};
	assign dwell_thr = {dwell_hi, dwell_lo};

	// software writes; period and select registers are plain storage
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			upper_lo   <= REG_RESET;
			upper_hi   <= REG_RESET;
			lower_lo   <= REG_RESET;
			lower_hi   <= REG_RESET;
			dwell_lo   <= REG_RESET;
			dwell_hi   <= REG_RESET;
			mon_ctrl   <= REG_RESET;
			ser_en_a   <= REG_RESET;
			ser_en_b   <= REG_RESET;
			cb_sel_a   <= REG_RESET;
			cb_sel_b   <= REG_RESET;
			cb_sel_c   <= REG_RESET;
			or_clear   <= REG_RESET;
			period_set <= '0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_UPPER_LO:  upper_lo <= reg_wdata_i;
				ADDR_UPPER_HI:  upper_hi <= reg_wdata_i;
				ADDR_LOWER_LO:  lower_lo <= reg_wdata_i;
				ADDR_LOWER_HI:  lower_hi <= reg_wdata_i;
				ADDR_DWELL_LO:  dwell_lo <= reg_wdata_i;
				ADDR_DWELL_HI:  dwell_hi <= reg_wdata_i;
				ADDR_MON_CTRL:  mon_ctrl <= reg_wdata_i;
				ADDR_PERIOD_0:  period_set[7:0]   <= reg_wdata_i;
				ADDR_PERIOD_1:  period_set[15:8]  <= reg_wdata_i;
				ADDR_PERIOD_2:  period_set[23:16] <= reg_wdata_i;
				ADDR_SER_EN_A:  ser_en_a <= reg_wdata_i;
				ADDR_SER_EN_B:  ser_en_b <= reg_wdata_i;
				ADDR_CB_SEL_A:  cb_sel_a <= reg_wdata_i;
				ADDR_CB_SEL_B:  cb_sel_b <= reg_wdata_i;
				ADDR_CB_SEL_C:  cb_sel_c <= reg_wdata_i;
				ADDR_OR_CLEAR:  or_clear <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// read mux, registered; unmapped offsets read zero
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_UPPER_LO:  reg_rdata_o <= upper_lo;
				ADDR_UPPER_HI:  reg_rdata_o <= upper_hi;
				ADDR_LOWER_LO:  reg_rdata_o <= lower_lo;
				ADDR_LOWER_HI:  reg_rdata_o <= lower_hi;
				ADDR_DWELL_LO:  reg_rdata_o <= dwell_lo;
				ADDR_DWELL_HI:  reg_rdata_o <= dwell_hi;
				ADDR_MON_CTRL:  reg_rdata_o <= mon_ctrl;
				ADDR_PERIOD_0:  reg_rdata_o <= period_set[7:0];
				ADDR_PERIOD_1:  reg_rdata_o <= period_set[15:8];
				ADDR_PERIOD_2:  reg_rdata_o <= period_set[23:16];
				ADDR_PEAK_LO:   reg_rdata_o <= peak_hold[7:0];
				ADDR_PEAK_HI:   reg_rdata_o <= {3'h0, peak_hold[12:8]};
				ADDR_SER_EN_A:  reg_rdata_o <= ser_en_a;
				ADDR_SER_EN_B:  reg_rdata_o <= ser_en_b;
				ADDR_CB_SEL_A:  reg_rdata_o <= cb_sel_a;
				ADDR_CB_SEL_B:  reg_rdata_o <= cb_sel_b;
				ADDR_CB_SEL_C:  reg_rdata_o <= cb_sel_c;
				ADDR_OR_CLEAR:  reg_rdata_o <= or_clear;
				ADDR_OR_STICKY: reg_rdata_o <= or_sticky;
				default:        reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ======================================================
	// input synchronisers: converter side is treated as foreign
	logic [NUM_CHAN*MAG_W-1:0] mag_s1, mag_s2;
	logic [NUM_CHAN-1:0]       ovr_s1, ovr_s2;
	logic [NUM_VCONV-1:0]      vc_s1, vc_s2;
	logic                      tick_s1, tick_s2;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mag_s1  <= '0;
			mag_s2  <= '0;
			ovr_s1  <= '0;
			ovr_s2  <= '0;
			vc_s1   <= '0;
			vc_s2   <= '0;
			tick_s1 <= 1'b0;
			tick_s2 <= 1'b0;
		end else begin
			mag_s1  <= mag_i;
			mag_s2  <= mag_s1;
			ovr_s1  <= overrange_i;
			ovr_s2  <= ovr_s1;
			vc_s1   <= vconv_over_i;
			vc_s2   <= vc_s1;
			tick_s1 <= dec_tick_i;
			tick_s2 <= tick_s1;
		end
	end

	// ======================================================
	// sticky overrange; set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			or_sticky <= 8'h00;
		end else begin
			or_sticky <= (or_sticky & ~or_clear) | vc_s2;
		end
	end

	// overrange delay line, so the flag lines up with its sample
	logic [NUM_CHAN-1:0] or_pipe [OR_LATENCY];
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < OR_LATENCY; i++) begin
				or_pipe[i] <= '0;
			end
		end else begin
			or_pipe[0] <= ovr_s2;
			for (int i = 1; i < OR_LATENCY; i++) begin
				or_pipe[i] <= or_pipe[i-1];
			end
		end
	end
	assign overrange_o = or_pipe[OR_LATENCY-1];

	// ======================================================
	// fast detect per channel
	logic [NUM_CHAN-1:0] fast_detect_flag;
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHAN; ch++) begin : g_fast
			logic [MAG_W-1:0]        mag;
			logic [DWELL_W-1:0]      dwell_cnt;
			logic                    flag;
			logic [FAST_LATENCY-3:0] hit_pipe;
			assign mag = mag_s2[ch*MAG_W +: MAG_W];
			// upper crossing sets at once; dwell below lower clears
			always_ff @(posedge clk_i) begin
				if (!rst_n_i) begin
					flag      <= 1'b0;
					dwell_cnt <= '0;
				end else if (mag > upper_thr) begin
					flag      <= 1'b1;
					dwell_cnt <= '0;
				end else if (mag >= lower_thr) begin
					dwell_cnt <= '0;
				end else if (flag) begin
					if (dwell_cnt >= dwell_thr) begin
						flag      <= 1'b0;
						dwell_cnt <= '0;
					end else begin
						dwell_cnt <= dwell_cnt + 16'h0001;
					end
				end
			end
			// two synchroniser stages plus this pipe give the fixed latency
			always_ff @(posedge clk_i) begin
				if (!rst_n_i) begin
					hit_pipe <= '0;
				end else begin
					hit_pipe <= {hit_pipe[FAST_LATENCY-4:0], flag};
				end
			end
			assign fast_detect_flag[ch] = hit_pipe[FAST_LATENCY-3];
		end
	endgenerate
	assign level_alarm_pin_o = fast_detect_flag;

	// ======================================================
	// peak detector over channel 0 magnitude
	logic                peak_en;
	logic                peak_en_d;
	logic [PERIOD_W-1:0] timer;
	logic [MAG_W-1:0]    peak_store;
	logic [MAG_W-1:0]    mag0;
	logic                frame_go;
	assign mag0    = mag_s2[MAG_W-1:0];
	assign peak_en = mon_ctrl[PEAK_EN_BIT];

	// timer counts decimated samples; periods of zero and one both transfer on every tick
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			peak_en_d  <= 1'b0;
			timer      <= '0;
			peak_store <= '0;
			peak_hold  <= '0;
			frame_go   <= 1'b0;
		end else begin
			peak_en_d <= peak_en;
			frame_go  <= 1'b0;
			if (!peak_en) begin
				timer <= '0;
			end else if (!peak_en_d) begin
				timer      <= period_set;
				peak_store <= mag0;
			end else if (tick_s2) begin
				if (timer <= 24'h000001) begin
					peak_hold  <= (mag0 > peak_store) ? mag0 : peak_store;
					timer      <= period_set;
					peak_store <= mag0;
					frame_go   <= 1'b1;
				end else begin
					timer      <= timer - 24'h000001;
					peak_store <= (mag0 > peak_store) ? mag0 : peak_store;
				end
			end
		end
	end

	// ======================================================
	// serial status frame: five subframes of start bit and 4 payload bits
	logic                  serial_en;
	logic [FRAME_BITS-1:0] frame_sr;
	logic [4:0]            frame_left;
	logic                  serial_bit;
	assign serial_en = ((ser_en_a[1:0] & SER_EN_A_MASK) == SER_EN_A_MASK)
		&& ser_en_b[SER_EN_B_BIT];

	// payload: three zero pad bits then the 13-bit peak, msb first
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			frame_sr   <= '0;
			frame_left <= 5'h00;
		end else if (frame_go && serial_en) begin
			frame_sr   <= {1'b1, 3'h0, peak_hold[12],
				1'b1, peak_hold[11:8], 1'b1, peak_hold[7:4],
				1'b1, peak_hold[3:0], 1'b1, 4'h0};
			frame_left <= 5'(FRAME_BITS);
		end else if (tick_s2 && frame_left != 5'h00) begin
			frame_sr   <= {frame_sr[FRAME_BITS-2:0], 1'b0};
			frame_left <= frame_left - 5'h01;
		end
	end
	assign serial_bit = (frame_left != 5'h00) ? frame_sr[FRAME_BITS-1] : 1'b0;

	// ======================================================
	// control bit mux; slots fill from the msb down
	function automatic logic pick(input logic [3:0] src, input int c);
		case (src)
			CB_SRC_OVER:  pick = or_pipe[OR_LATENCY-1][c];
			CB_SRC_FAST:  pick = fast_detect_flag[c];
			CB_SRC_SERIAL: pick = (cb_sel_c == SERIAL_SELECT) ? serial_bit : 1'b0;
			default:      pick = 1'b0;
		endcase
	endfunction : pick

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_bits_o <= '0;
		end else begin
			ctrl_bits_o[2] <= (control_bits_per_sample_i >= 2'h1)
				? pick(cb_sel_a[3:0], 0) : 1'b0;
			ctrl_bits_o[1] <= (control_bits_per_sample_i >= 2'h2)
				? pick(cb_sel_a[7:4], 0) : 1'b0;
			ctrl_bits_o[0] <= (control_bits_per_sample_i >= 2'h3)
				? pick(cb_sel_b[3:0], 1) : 1'b0;
		end
	end

	// ======================================================
	// checks
	a_sticky_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(vc_s2[0]) |=> or_sticky[0]) else $error("sticky bit lost");
	a_sticky_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(or_clear[0] && !vc_s2[0]) |=> !or_sticky[0]) else $error("sticky not cleared");
	a_fast_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(g_fast[0].mag > upper_thr) |=> g_fast[0].flag) else $error("alarm not set");
	a_fast_latency: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(g_fast[0].flag) |-> ##26 fast_detect_flag[0]) else $error("alarm latency");
	a_fast_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(g_fast[0].flag && g_fast[0].mag >= lower_thr) |=> g_fast[0].flag)
		else $error("alarm dropped above lower");
	a_dwell_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(g_fast[0].mag >= lower_thr) |=> g_fast[0].dwell_cnt == 16'h0000)
		else $error("dwell not restarted");
	a_timer_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(peak_en) |=> timer == $past(period_set)) else $error("timer not loaded");
	a_peak_xfer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(peak_en && peak_en_d && tick_s2 && timer == 24'h000001) |=> frame_go)
		else $error("no peak transfer");
	a_or_align: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ovr_s2[0] |-> ##(OR_LATENCY) overrange_o[0]) else $error("overrange misaligned");
	a_serial_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!serial_en && frame_left == 5'h00) |=> frame_left == 5'h00)
		else $error("frame without enable");
endmodule : adc_level_monitor

// ==== verification/monitor_frame_receiver.sv ====
`timescale 1ns/10ps
// ==========================================================
// link receiver model: rebuilds monitor frames from the top control bit
module monitor_frame_receiver (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        strobe_i,
	input  wire logic        bit_i,
	output logic      [12:0] peak_o,
	output logic      [7:0]  frames_o,
	output logic      [7:0]  bad_o
);
	logic [23:0] shift;
	logic [4:0]  count;
	logic [24:0] word;

	assign word = {shift, bit_i};

	// idle zeros are skipped; a one opens a frame of 25 bits, msb first
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			shift    <= 24'h000000;
			count    <= 5'h00;
			peak_o   <= 13'h0000;
			frames_o <= 8'h00;
			bad_o    <= 8'h00;
		end else if (strobe_i && (count != 5'h00 || bit_i)) begin
			shift <= word[23:0];
			count <= (count == 5'h18) ? 5'h00 : count + 5'h01;
			if (count == 5'h18) begin
				// every subframe must open with its start bit
				if ({word[24], word[19], word[14], word[9], word[4]} == 5'h1F) begin
					peak_o   <= {word[20], word[18:15], word[13:10], word[8:5]};
					frames_o <= frames_o + 8'h01;
				end else begin
					bad_o <= bad_o + 8'h01;
				end
			end
		end
	end
endmodule : monitor_frame_receiver

// ==== verification/adc_level_monitor_bench.sv ====
`timescale 1ns/10ps
// ==========================================================
// bench: register accesses, sample stimulus and link receiver
module adc_level_monitor_bench;
	import level_monitor_pkg::*;
	localparam int OR_LAT = 4;
	logic        clk_i, rst_n_i, dec_tick_i, reg_wr_i, reg_rd_i, tick_run;
	logic [25:0] mag_i;
	logic [1:0]  overrange_i, control_bits_per_sample_i, level_alarm_pin_o, overrange_o;
	logic [7:0]  vconv_over_i, reg_wdata_i, reg_rdata_o, d, frames, bad;
	logic [11:0] reg_addr_i;
	logic [2:0]  ctrl_bits_o;
	logic [12:0] peak;
	int          fails, compares, n, lat;
	logic        cb;

	adc_level_monitor #(.OR_LATENCY(OR_LAT)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.mag_i(mag_i), .overrange_i(overrange_i), .vconv_over_i(vconv_over_i),
		.dec_tick_i(dec_tick_i), .control_bits_per_sample_i(control_bits_per_sample_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.level_alarm_pin_o(level_alarm_pin_o), .overrange_o(overrange_o),
		.ctrl_bits_o(ctrl_bits_o));

	monitor_frame_receiver rx_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .strobe_i(dec_tick_i),
		.bit_i(ctrl_bits_o[2]), .peak_o(peak), .frames_o(frames), .bad_o(bad));

	// ==========================================================
	// clock and decimated tick, one tick every eight cycles
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		dec_tick_i = 1'b0;
		forever begin
			repeat (7) @(posedge clk_i);
			#1 dec_tick_i = tick_run;
			@(posedge clk_i);
			#1 dec_tick_i = 1'b0;
		end
	end

	// ==========================================================
	// access tasks; inputs always move 1 ns after the edge
	task automatic step(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : step
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		reg_addr_i  = a;
		reg_wdata_i = v;
		reg_wr_i    = 1'b1;
		step(1);
		reg_wr_i    = 1'b0;
		step(1);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		reg_addr_i = a;
		reg_rd_i   = 1'b1;
		step(1);
		reg_rd_i   = 1'b0;
		d          = reg_rdata_o;
		step(1);
	endtask : rd
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic conclude;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	// ==========================================================
	// main sequence
	initial begin
		{rst_n_i, reg_wr_i, reg_rd_i, tick_run, overrange_i, vconv_over_i} = '0;
		{reg_addr_i, reg_wdata_i, mag_i, control_bits_per_sample_i} = '0;
		fails = 0;
		compares = 0;
		step(16);
		rst_n_i = 1'b1;
		rd(ADDR_MON_CTRL); chk("mon_ctrl", d, 16'(REG_RESET));
		rd(ADDR_OR_STICKY); chk("sticky", d, 16'(REG_RESET));
		rd(12'h000); chk("unmapped", d, 16'h0000);
		// thresholds with hysteresis, dwell of 40 cycles
		wr(ADDR_UPPER_LO, 8'hFF); wr(ADDR_UPPER_HI, 8'h0F);
		wr(ADDR_LOWER_LO, 8'h1D); wr(ADDR_LOWER_HI, 8'h0A);
		wr(ADDR_DWELL_LO, 8'h28); wr(ADDR_DWELL_HI, 8'h00);
		rd(ADDR_LOWER_HI); chk("lower_hi", d, 16'h000A);
		rd(ADDR_DWELL_LO); chk("dwell_lo", d, 16'h0028);
		wr(ADDR_CB_SEL_A, {4'h0, CB_SRC_FAST});
		control_bits_per_sample_i = 2'h1;
		// one sample above upper, then hold between the thresholds
		mag_i = {13'h0100, 13'h1000};
		step(1);
		mag_i = {13'h0100, 13'h0B00};
		n = 0;
		while (level_alarm_pin_o[0] !== 1'b1 && n < 60) begin
			step(1);
			n++;
		end
		chk("alarm_latency", n[15:0], 16'(FAST_LATENCY));
		chk("alarm_chan1", level_alarm_pin_o[1], 16'h0000);
		step(2); chk("cb_fast", ctrl_bits_o[2], 16'h0001);
		step(40); chk("alarm_hold_mid", level_alarm_pin_o[0], 16'h0001);
		// below lower for less than the dwell, brief recovery, then below again
		mag_i[12:0] = 13'h0100; step(35);
		mag_i[12:0] = 13'h0B00; step(1);
		mag_i[12:0] = 13'h0100;
		step(45); chk("alarm_restart", level_alarm_pin_o[0], 16'h0001);
		step(55); chk("alarm_clear", level_alarm_pin_o[0], 16'h0000);
		// overrange delay, with and without a control bit slot
		wr(ADDR_CB_SEL_A, {4'h0, CB_SRC_OVER});
		for (int c = 0; c < 2; c++) begin
			control_bits_per_sample_i = c[1:0];
			overrange_i = 2'h1;
			lat = 0;
			cb = 1'b0;
			for (int k = 1; k < 13; k++) begin
				step(1);
				overrange_i = 2'h0;
				if (overrange_o[0] === 1'b1 && lat == 0) lat = k;
				cb = cb | ctrl_bits_o[2];
			end
			chk("or_latency", lat[15:0], 16'(2 + OR_LAT));
			chk("cb_over", cb, c[15:0]);
		end
		// sticky bits, cleared by writing one then zero
		vconv_over_i = 8'hA5; step(1);
		vconv_over_i = 8'h00; step(5);
		rd(ADDR_OR_STICKY); chk("sticky_set", d, 16'h00A5);
		wr(ADDR_OR_CLEAR, 8'h05); wr(ADDR_OR_CLEAR, 8'h00);
		wr(ADDR_OR_STICKY, 8'hFF);
		rd(ADDR_OR_STICKY); chk("sticky_clr", d, 16'h00A0);
		// peak monitor over 40 ticks, sent as serial frames in the top slot
		mag_i = {13'h0100, 13'h1ABC};
		wr(ADDR_PERIOD_0, 8'h28); wr(ADDR_PERIOD_1, 8'h00); wr(ADDR_PERIOD_2, 8'h00);
		wr(ADDR_SER_EN_A, 8'h03); wr(ADDR_SER_EN_B, 8'h02);
		wr(ADDR_CB_SEL_C, SERIAL_SELECT); wr(ADDR_CB_SEL_A, {4'h0, CB_SRC_SERIAL});
		control_bits_per_sample_i = 2'h1;
		tick_run = 1'b1;
		wr(ADDR_MON_CTRL, 8'h02);
		step(1100);
		rd(ADDR_PEAK_LO); chk("peak_lo", d, 16'h00BC);
		wr(ADDR_PEAK_LO, 8'h00);
		rd(ADDR_PEAK_HI); chk("peak_hi", d, 16'h001A);
		rd(ADDR_PEAK_LO); chk("peak_ro", d, 16'h00BC);
		chk("frames_seen", frames != 8'h00, 16'h0001);
		chk("frame_peak", peak, 16'h1ABC);
		chk("frame_bad", bad, 16'h0000);
		conclude();
	end
endmodule : adc_level_monitor_bench
